// >>> verilog/ata_card_host_port.sv
// Host-side pin logic for a card or drive in task-file mode
`timescale 1ns/1ps
`default_nettype none

module ata_card_host_port
    import ata_card_host_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire cmd_t i_cmd,
    input wire logic i_card_reset,
    output logic o_busy,
    output logic o_ack,
    output logic [DATA_W-1:0] o_rdata,
    output pin_status_t o_status,
    output logic o_ata_chip_select_one_n,
    output logic o_task_file_select_n,
    output logic o_reg_addr_bit2,
    output logic o_reg_addr_bit1,
    output logic o_reg_addr_bit0,
    output logic o_io_read_strobe_n,
    output logic o_io_write_strobe_n,
    output logic o_card_hw_reset_n,
    output logic [BYTE_W-1:0] o_data_bus_high,
    output logic [BYTE_W-1:0] o_data_bus_low,
    output logic o_data_bus_oe,
    input wire logic [BYTE_W-1:0] i_data_bus_high,
    input wire logic [BYTE_W-1:0] i_data_bus_low,
    input wire logic i_card_irq_in,
    input wire logic i_io_ready_in,
    input wire logic i_card_detect_a_n,
    input wire logic i_card_detect_b_n
);

    // Two-stage synchronisers for every pin input
    logic [DATA_W-1:0] data_s1_r, data_s2_r;
    logic [3:0] lvl_s1_r, lvl_s2_r;
    logic irq_s2, ready_s2, cda_s2, cdb_s2;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_s1_r <= DATA_IDLE;
            data_s2_r <= DATA_IDLE;
            lvl_s1_r <= 4'hc;
            lvl_s2_r <= 4'hc;
        end else begin
            data_s1_r <= {i_data_bus_high, i_data_bus_low};
            data_s2_r <= data_s1_r;
            lvl_s1_r <= {i_card_detect_b_n, i_card_detect_a_n,
                         i_io_ready_in, i_card_irq_in};
            lvl_s2_r <= lvl_s1_r;
        end
    end

    assign irq_s2 = lvl_s2_r[0];
    assign ready_s2 = lvl_s2_r[1];
    assign cda_s2 = lvl_s2_r[2];
    assign cdb_s2 = lvl_s2_r[3];

    // Status: irq high is pending, both detects low is a seated card
    pin_status_t status_r, status_nxt;
    logic hw_reset_n_r, hw_reset_n_nxt;

    always_comb begin
        status_nxt.irq_pending = irq_s2;
        status_nxt.io_ready = ready_s2;
        status_nxt.card_present = !cda_s2 && !cdb_s2;
        hw_reset_n_nxt = !i_card_reset;
    end

    // Card held in reset while our own reset is asserted
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_r <= '0;
            hw_reset_n_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            hw_reset_n_r <= hw_reset_n_nxt;
        end
    end

    // Access sequencer state
    state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    cmd_t cmd_r, cmd_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    logic busy_r, busy_nxt;
    logic cs1_n_r, cs1_n_nxt, tf_n_r, tf_n_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt;
    logic oe_r, oe_nxt;
    logic [DATA_W-1:0] dout_r, dout_nxt;
    logic active;

    // Phases: setup, strobe (stretched while not ready), hold
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        cmd_nxt = cmd_r;
        rdata_nxt = rdata_r;
        ack_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (i_req) begin
                    cmd_nxt = i_cmd;
                    cnt_nxt = SETUP_LOAD;
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (cnt_r == CNT_ZERO) begin
                    cnt_nxt = PULSE_LOAD;
                    state_nxt = ST_STROBE;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_STROBE: begin
                if (cnt_r != CNT_ZERO) begin
                    cnt_nxt = cnt_r - 4'h1;
                end else if (ready_s2) begin
                    // Sampled data is two cycles old, still inside pulse
                    if (cmd_r.wide) begin
                        rdata_nxt = data_s2_r;
                    end else begin
                        rdata_nxt = {BYTE_ZERO, data_s2_r[BYTE_W-1:0]};
                    end
                    cnt_nxt = HOLD_LOAD;
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_r == CNT_ZERO) begin
                    ack_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Pin levels follow the next phase so every pin is a flip-flop
    always_comb begin
        active = (state_nxt != ST_IDLE);
        busy_nxt = active;
        cs1_n_nxt = !(active && cmd_nxt.cs_one);
        tf_n_nxt = !(active && !cmd_nxt.cs_one);
        addr_nxt = active ? cmd_nxt.addr : ADDR_IDLE;
        rd_n_nxt = !(state_nxt == ST_STROBE && !cmd_nxt.write);
        wr_n_nxt = !(state_nxt == ST_STROBE && cmd_nxt.write);
        oe_nxt = active && cmd_nxt.write;
        if (!oe_nxt) begin
            dout_nxt = DATA_IDLE;
        end else if (cmd_nxt.wide) begin
            dout_nxt = cmd_nxt.wdata;
        end else begin
            dout_nxt = {BYTE_ZERO, cmd_nxt.wdata[BYTE_W-1:0]};
        end
    end

    // Register the sequencer and all pins but the card reset
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_IDLE;
            cnt_r <= CNT_ZERO;
            cmd_r <= '0;
            rdata_r <= DATA_IDLE;
            ack_r <= 1'b0;
            busy_r <= 1'b0;
            cs1_n_r <= 1'b1;
            tf_n_r <= 1'b1;
            addr_r <= ADDR_IDLE;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            oe_r <= 1'b0;
            dout_r <= DATA_IDLE;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            cmd_r <= cmd_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
            busy_r <= busy_nxt;
            cs1_n_r <= cs1_n_nxt;
            tf_n_r <= tf_n_nxt;
            addr_r <= addr_nxt;
            rd_n_r <= rd_n_nxt;
            wr_n_r <= wr_n_nxt;
            oe_r <= oe_nxt;
            dout_r <= dout_nxt;
        end
    end

    assign o_busy = busy_r;
    assign o_ack = ack_r;
    assign o_rdata = rdata_r;
    assign o_status = status_r;
    assign o_ata_chip_select_one_n = cs1_n_r;
    assign o_task_file_select_n = tf_n_r;
    assign o_reg_addr_bit2 = addr_r[2];
    assign o_reg_addr_bit1 = addr_r[1];
    assign o_reg_addr_bit0 = addr_r[0];
    assign o_io_read_strobe_n = rd_n_r;
    assign o_io_write_strobe_n = wr_n_r;
    assign o_card_hw_reset_n = hw_reset_n_r;
    assign o_data_bus_high = dout_r[DATA_W-1:BYTE_W];
    assign o_data_bus_low = dout_r[BYTE_W-1:0];
    assign o_data_bus_oe = oe_r;

    // Checks on the pin behaviour
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    AST_CS_ONE: assert property (
        !o_ata_chip_select_one_n |-> cmd_r.cs_one && o_task_file_select_n)
        else $error("chip select one low without its request");
    AST_TF_SELECT: assert property (
        (!o_io_read_strobe_n || !o_io_write_strobe_n) && !cmd_r.cs_one
        |-> !o_task_file_select_n)
        else $error("strobe without task-file select");
    AST_ADDR_STABLE: assert property (
        $fell(o_io_read_strobe_n) |->
        {o_reg_addr_bit2, o_reg_addr_bit1, o_reg_addr_bit0} == cmd_r.addr
        ##1 $stable({o_reg_addr_bit2, o_reg_addr_bit1, o_reg_addr_bit0}))
        else $error("register address wrong or moving during read");
    AST_IRQ_PENDING: assert property (
        o_status.irq_pending == $past(i_card_irq_in, 3))
        else $error("interrupt pending does not follow input");
    AST_LOW_BYTE: assert property (
        o_data_bus_oe && !cmd_r.wide |-> o_data_bus_high == BYTE_ZERO
        && o_data_bus_low == cmd_r.wdata[7:0])
        else $error("task-file write not on low byte");
    AST_WIDE_DATA: assert property (
        o_data_bus_oe && cmd_r.wide
        |-> {o_data_bus_high, o_data_bus_low} == cmd_r.wdata)
        else $error("data transfer word not on full bus");
    AST_READY_END: assert property (
        $rose(o_io_read_strobe_n) || $rose(o_io_write_strobe_n)
        |-> $past(ready_s2))
        else $error("strobe ended while device not ready");
    AST_PRESENT: assert property (
        o_status.card_present ==
        (!$past(i_card_detect_a_n, 3) && !$past(i_card_detect_b_n, 3)))
        else $error("card present does not follow detects");
    // First edge after release still shows the reset level, so skip it
    AST_HW_RESET: assert property (
        $past(i_rst_n) |-> o_card_hw_reset_n == !$past(i_card_reset))
        else $error("hardware reset output wrong");
    AST_READ_PULSE: assert property (
        $fell(o_io_read_strobe_n) |-> !o_io_read_strobe_n[*4])
        else $error("read strobe shorter than least pulse");
    AST_WRITE_PULSE: assert property (
        $fell(o_io_write_strobe_n) |-> !o_io_write_strobe_n[*4])
        else $error("write strobe shorter than least pulse");
    // Data must still stand on the bus in the hold cycle after the strobe
    AST_WRITE_HOLD: assert property (
        $rose(o_io_write_strobe_n) |-> o_data_bus_oe)
        else $error("bus dropped before write hold ended");
    AST_BUS_RELEASE: assert property (
        o_data_bus_oe |-> cmd_r.write && o_busy && o_io_read_strobe_n)
        else $error("bus driven outside a write cycle");

    COV_READ: cover property ($rose(o_io_read_strobe_n) ##[1:4] o_ack);
    COV_WIDE_WRITE: cover property (
        !o_io_write_strobe_n && cmd_r.wide);
    COV_STRETCH: cover property (
        !o_io_read_strobe_n [*6] ##1 o_io_read_strobe_n);
    COV_CARD_IRQ: cover property (
        o_status.card_present && o_status.irq_pending);

endmodule

`default_nettype wire

// >>> verilog/ata_card_host_pkg.sv
// Constants, types and timing for the card task-file host port
package ata_card_host_pkg;

    // Clock period and strobe timing in nanoseconds
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETUP_NS = 70;
    localparam int PULSE_NS = 165;
    localparam int HOLD_NS = 30;

    // Least times round up to whole cycles
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Phase counter loads cycles minus one and counts down to zero
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC - 1);

    // Bus widths and idle values
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 3;
    localparam logic [DATA_W-1:0] DATA_IDLE = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_IDLE = 3'h0;

    // Strobe phases, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_HOLD = 4'b1000
    } state_t;

    // One access request from the controller core
    typedef struct packed {
        logic write;
        logic wide;
        logic cs_one;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cmd_t;

    // Synchronised card-side levels
    typedef struct packed {
        logic card_present;
        logic irq_pending;
        logic io_ready;
    } pin_status_t;

endpackage

// >>> bench/ata_card_model.sv
// Behavioural card on the far side of the host port
`timescale 1ns/1ps
`default_nettype none
module ata_card_model
    import ata_card_host_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_cs_one_n,
    input wire logic i_tf_sel_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [DATA_W-1:0] i_host_data,
    input wire logic i_host_oe,
    input wire logic [3:0] i_stall,
    output logic [DATA_W-1:0] o_bus,
    output logic o_io_ready_in
);
    logic [DATA_W-1:0] mem_r [16];
    logic [3:0] wait_r;
    logic prev_r;
    logic sel;
    logic strobe;
    logic [3:0] idx;

    // Decode of the select pair and strobes
    assign idx = {i_cs_one_n, i_addr};
    assign sel = !(i_cs_one_n && i_tf_sel_n);
    assign strobe = sel && !(i_rd_n && i_wr_n);
    assign o_io_ready_in = (wait_r == 4'h0);

    // Wire level: host, else card on reads, else the pull-downs
    always_comb begin
        if (i_host_oe) begin
            o_bus = i_host_data;
        end else if (sel && !i_rd_n) begin
            o_bus = mem_r[idx];
        end else begin
            o_bus = DATA_IDLE;
        end
    end

    initial begin
        wait_r = 4'h0;
        prev_r = 1'b0;
        for (int i = 0; i < 16; i++) begin
            mem_r[i] = DATA_IDLE;
        end
    end

    // Keeps the whole word, so a byte read shows a live high byte
    always @(posedge i_clock) begin
        prev_r <= strobe;
        if (sel && !i_wr_n) begin
            mem_r[idx] <= o_bus;
        end
        if (strobe && !prev_r) begin
            wait_r <= i_stall;
        end else if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> bench/ata_card_host_port_test.sv
// Self-checking bench for the card task-file host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin \
    miscompares++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module ata_card_host_port_test import ata_card_host_pkg::*;;
    logic i_clock, i_rst_n, i_req, i_card_reset, irq, det_a_n, det_b_n;
    logic busy, ack, cs1_n, tf_n, a2, a1, a0, rd_n, wr_n, crst_n, oe, rdy;
    cmd_t i_cmd, cur;
    logic [DATA_W-1:0] rdata, bus;
    logic [BYTE_W-1:0] dhi, dlo;
    pin_status_t status;
    logic [3:0] stall;
    logic [DATA_W-1:0] exp_mem [16];
    int miscompares, n_checks, cycles, seed;

    ata_card_host_port i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_req(i_req), .i_cmd(i_cmd), .i_card_reset(i_card_reset),
        .o_busy(busy), .o_ack(ack), .o_rdata(rdata), .o_status(status),
        .o_ata_chip_select_one_n(cs1_n), .o_task_file_select_n(tf_n),
        .o_reg_addr_bit2(a2), .o_reg_addr_bit1(a1), .o_reg_addr_bit0(a0),
        .o_io_read_strobe_n(rd_n), .o_io_write_strobe_n(wr_n),
        .o_card_hw_reset_n(crst_n), .o_data_bus_high(dhi),
        .o_data_bus_low(dlo), .o_data_bus_oe(oe),
        .i_data_bus_high(bus[15:8]), .i_data_bus_low(bus[7:0]),
        .i_card_irq_in(irq), .i_io_ready_in(rdy),
        .i_card_detect_a_n(det_a_n), .i_card_detect_b_n(det_b_n));
    ata_card_model i_card (.i_clock(i_clock), .i_cs_one_n(cs1_n),
        .i_tf_sel_n(tf_n), .i_addr({a2, a1, a0}), .i_rd_n(rd_n),
        .i_wr_n(wr_n), .i_host_data({dhi, dlo}), .i_host_oe(oe),
        .i_stall(stall), .o_bus(bus), .o_io_ready_in(rdy));

    // Byte accesses carry only the low byte, high byte reads as zero
    function automatic logic [DATA_W-1:0] narrow(input cmd_t c,
                                                  input logic [15:0] w);
        return c.wide ? w : {BYTE_ZERO, w[7:0]};
    endfunction

    task automatic stop_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One access; a poke is a request while busy, which must be dropped
    task automatic access(input cmd_t c, input logic [3:0] s,
                          input logic poke);
        int k;
        int lat;
        cmd_t junk;
        k = 0;
        // Take edge, setup, least pulse and hold, one more per stall cycle
        lat = 1 + SETUP_CYC + PULSE_CYC + HOLD_CYC + int'(s);
        junk = c;
        junk.write = 1'b1;
        junk.wdata = ~c.wdata;
        i_req = 1'b1;
        i_cmd = c;
        stall = s;
        cur = c;
        do begin
            @(posedge i_clock);
            k++;
            @(negedge i_clock);
            // One change per step and none at exit, so the next call is clean
            if (k == 1 || k == 5) begin
                i_req = 1'b0;
                i_cmd = c;
            end else if (k == 4 && poke) begin
                i_req = 1'b1;
                i_cmd = junk;
            end
            if (k == 2) `CHK("busy", 1'b1, busy)
        end while (ack !== 1'b1 && k < 100);
        `CHK("latency", lat, k)
        if (s >= 4'h6) `CHK("stretch", 1'b1, k > 9 && k <= s + 13)
        if (c.write) begin
            exp_mem[{!c.cs_one, c.addr}] = narrow(c, c.wdata);
        end else begin
            `CHK("rdata", narrow(c, exp_mem[{!c.cs_one, c.addr}]), rdata)
        end
    endtask

    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    // Pin monitor: idle release and the pins of each strobe cycle
    // Looks at the falling edge, where registered pins have settled
    always @(negedge i_clock) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            stop_test();
        end
        if (busy === 1'b0) begin
            `CHK("idle_oe", 1'b0, oe)
            `CHK("idle_sel", 2'h3, {cs1_n, tf_n})
        end
        if (rd_n === 1'b0 || wr_n === 1'b0) begin
            `CHK("cs1", !cur.cs_one, cs1_n)
            `CHK("tfsel", cur.cs_one, tf_n)
            `CHK("addr", cur.addr, {a2, a1, a0})
            `CHK("rd", cur.write, rd_n)
            `CHK("wr", !cur.write, wr_n)
            `CHK("oe", cur.write, oe)
            if (cur.write) `CHK("dout", narrow(cur, cur.wdata), {dhi, dlo})
        end
    end

    initial begin
        logic [31:0] r;
        logic [31:0] s;
        cmd_t c;
        seed = 32'h4ea7;
        {i_rst_n, i_req, i_card_reset, irq, stall} = '0;
        {det_a_n, det_b_n} = 2'h3;
        i_cmd = '0;
        cur = '0;
        for (int i = 0; i < 16; i++) exp_mem[i] = DATA_IDLE;
        repeat (12) @(negedge i_clock);
        `CHK("rst_out", 1'b0, crst_n)
        i_rst_n = 1'b1;
        i_card_reset = 1'b1;
        repeat (2) @(negedge i_clock);
        `CHK("card_rst", 1'b0, crst_n)
        i_card_reset = 1'b0;
        @(negedge i_clock);
        `CHK("card_rst", 1'b1, crst_n)
        // Every detect and interrupt level, three edges to settle
        for (int i = 0; i < 8; i++) begin
            {det_a_n, det_b_n, irq} = i[2:0];
            repeat (4) @(negedge i_clock);
            `CHK("status", {i[2:1] == 2'h0, i[0], 1'b1}, status)
        end
        // Corners first: each width and select at both end addresses
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            s = $random(seed);
            c = r[21:0];
            if (i < 16) begin
                {c.addr, c.cs_one, c.wide, c.write} = {{3{i[3]}}, i[2:1], !i[0]};
                s = '0;
            end
            access(c, (s[3:2] == 2'h0) ? s[7:4] : 4'h0, i >= 16 && s[8]);
        end
        stop_test();
    end
endmodule
`default_nettype wire
